// ===== hdl/twd_pkg.sv
// Purpose: shared constants and carrier types for the tape word deskew reproduce block
// Assumes: 10 MHz system clock, nine data tracks, one frame-sync track, one clock track
// Notes:   all cycle counts derive from printed times and the clock rate

package twd_pkg;

  // ----------------------------------------------------------------
  // clock and track layout
  // ----------------------------------------------------------------
  localparam int unsigned TWD_CLK_HZ     = 10_000_000;              // system clock rate
  localparam int unsigned TWD_CLK_NS     = 1_000_000_000 / TWD_CLK_HZ; // clock period in ns
  localparam int unsigned TWD_DATA_BITS  = 9;                       // data tracks per word
  localparam int unsigned TWD_TRACKS     = TWD_DATA_BITS + 1;       // data plus frame sync
  localparam int unsigned TWD_PAIRS      = TWD_TRACKS / 2;          // two-bit storage units
  localparam int unsigned TWD_PINS       = TWD_TRACKS + 1;          // plus clock track
  localparam int unsigned TWD_FSYNC_IDX  = 0;                       // frame sync bit position
  localparam int unsigned TWD_DATA_LSB   = 1;                       // first data bit position
  localparam int unsigned TWD_CLKTRK_IDX = TWD_TRACKS;              // clock track pin position

  // ----------------------------------------------------------------
  // strobe timing
  // ----------------------------------------------------------------
  localparam int unsigned TWD_GAP_NS     = 1500;                    // strobe to strobe spacing
  localparam int unsigned TWD_DLY_MIN_NS = 4000;                    // shortest first delay
  localparam int unsigned TWD_DLY_MAX_NS = 25000;                   // longest first delay
  localparam int unsigned TWD_GAP_CYC    = TWD_GAP_NS / TWD_CLK_NS;
  localparam int unsigned TWD_DLY_MIN_CYC = (TWD_DLY_MIN_NS + TWD_CLK_NS - 1) / TWD_CLK_NS;
  localparam int unsigned TWD_DLY_MAX_CYC = TWD_DLY_MAX_NS / TWD_CLK_NS;
  localparam int unsigned TWD_CNT_W      = 8;                       // holds the longest delay
  localparam int unsigned TWD_DLY_LEAD   = 2;                       // load offset of delay count

  typedef logic [TWD_CNT_W-1:0] twd_cnt_type;

  // ----------------------------------------------------------------
  // sequencer states, gray along idle-delay-gapA-gapB
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    TWD_SEQ_IDLE  = 2'b00,
    TWD_SEQ_DELAY = 2'b01,
    TWD_SEQ_GAPA  = 2'b11,
    TWD_SEQ_GAPB  = 2'b10
  } twd_seq_state_type;

  // ----------------------------------------------------------------
  // carriers and module state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic converterClear;                 // first strobe
    logic demuxClock;                     // second strobe
    logic transferCmd;                    // third strobe
  } twd_strobe_type;

  typedef struct packed
  {
    twd_seq_state_type state;             // sequencer position
    twd_cnt_type       cnt;               // cycles left in phase
    twd_strobe_type    stb;               // registered strobes
    logic              busy;              // sequence running
    logic              overrun;           // trigger ignored pulse
  } twd_seq_reg_type;

  typedef struct packed
  {
    logic [1:0] held;                     // stored track bits
    logic [1:0] outPulse;                 // transfer pulses
  } twd_pair_reg_type;

  typedef struct packed
  {
    logic [TWD_PINS-1:0]      syncA;      // first synchroniser stage
    logic [TWD_PINS-1:0]      syncB;      // second synchroniser stage
    logic [TWD_PINS-1:0]      prev;       // last settled level
    logic [TWD_PINS-1:0]      pulse;      // one-cycle rise strobes
    logic [TWD_DATA_BITS-1:0] convData;   // converter input register
    logic                     convLoad;   // converter word ready
    logic                     cmdDly;     // transfer command, one late
    logic                     afterClr;   // between clear and command
    logic                     lateBit;    // bit arrived after clear
  } twd_top_reg_type;

  localparam twd_seq_reg_type  TWD_SEQ_RST  = '{state: TWD_SEQ_IDLE, default: '0};
  localparam twd_pair_reg_type TWD_PAIR_RST = '0;
  localparam twd_top_reg_type  TWD_TOP_RST  = '0;

endpackage

// ===== hdl/twd_bit_pair.sv
// Purpose: two independent one-bit track stores that release on the transfer command
// Assumes: set pulses and transfer are one-cycle strobes on clk
// Notes:   a set in the transfer cycle is kept for the next word

`timescale 1ns/1ps
`default_nettype none

module twd_bit_pair
  import twd_pkg::*;
(
  input  wire logic       clk,        // system clock
  input  wire logic       rstn,       // async reset, active low
  input  wire logic [1:0] setPulse,   // recovered one per track
  input  wire logic       transfer,   // storage transfer command
  output var  logic [1:0] outPulse,   // one pulse per stored one
  output var  logic [1:0] held        // stored bits
);

  twd_pair_reg_type q;                // registered state
  twd_pair_reg_type d;                // next state

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    // only stored ones leave as pulses, zeros stay silent
    d.outPulse = transfer ? q.held : 2'b00;
    // command empties the store
    d.held = transfer ? 2'b00 : q.held;
    // a pulse sets its bit, winning over the clear
    d.held = d.held | setPulse;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= TWD_PAIR_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign outPulse = q.outPulse;
  assign held     = q.held;

endmodule

`default_nettype wire

// ===== hdl/twd_strobe_seq.sv
// Purpose: delay sequence giving clear, demux clock and transfer strobes per clock-track pulse
// Assumes: trigger is a one-cycle strobe; firstDelay is a static setting on clk
// Notes:   a trigger while the sequence runs is dropped and flagged

`timescale 1ns/1ps
`default_nettype none

module twd_strobe_seq
  import twd_pkg::*;
#(
  parameter int unsigned GAP_CYC     = TWD_GAP_CYC,        // strobe spacing in cycles
  parameter int unsigned DLY_MIN_CYC = TWD_DLY_MIN_CYC,    // first delay floor
  parameter int unsigned DLY_MAX_CYC = TWD_DLY_MAX_CYC     // first delay ceiling
)
(
  input  wire logic           clk,          // system clock
  input  wire logic           rstn,         // async reset, active low
  input  wire logic           trigger,      // clock-track strobe
  input  wire twd_cnt_type    firstDelay,   // requested first delay, cycles
  output var  twd_strobe_type strobes,      // three strobes
  output var  logic           busy,         // sequence running
  output var  logic           overrun       // trigger dropped
);

  localparam twd_cnt_type MIN_C = twd_cnt_type'(DLY_MIN_CYC);
  localparam twd_cnt_type MAX_C = twd_cnt_type'(DLY_MAX_CYC);
  localparam twd_cnt_type GAP_C = twd_cnt_type'(GAP_CYC - 1);
  localparam twd_cnt_type LEAD  = twd_cnt_type'(TWD_DLY_LEAD);

  twd_seq_reg_type q;                       // registered state
  twd_seq_reg_type d;                       // next state
  twd_cnt_type     effDelay;                // clamped first delay

  // ----------------------------------------------------------------
  // clamp the setting to the adjustable range
  // ----------------------------------------------------------------
  always_comb
  begin
    if (firstDelay < MIN_C)
    begin
      effDelay = MIN_C;
    end
    else if (firstDelay > MAX_C)
    begin
      effDelay = MAX_C;
    end
    else
    begin
      effDelay = firstDelay;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    d         = q;
    d.stb     = '0;
    d.overrun = trigger && (q.state != TWD_SEQ_IDLE);
    d.cnt     = (q.cnt != '0) ? q.cnt - twd_cnt_type'(1) : q.cnt;
    unique case (q.state)
      TWD_SEQ_IDLE:
      begin
        // wait out the skew window before clearing
        if (trigger)
        begin
          d.state = TWD_SEQ_DELAY;
          d.cnt   = effDelay - LEAD;
        end
      end
      TWD_SEQ_DELAY:
      begin
        // first strobe: converter clear
        if (q.cnt == '0)
        begin
          d.stb.converterClear = 1'b1;
          d.state = TWD_SEQ_GAPA;
          d.cnt   = GAP_C;
        end
      end
      TWD_SEQ_GAPA:
      begin
        // second strobe: demux clock
        if (q.cnt == '0)
        begin
          d.stb.demuxClock = 1'b1;
          d.state = TWD_SEQ_GAPB;
          d.cnt   = GAP_C;
        end
      end
      TWD_SEQ_GAPB:
      begin
        // third strobe: storage transfer
        if (q.cnt == '0)
        begin
          d.stb.transferCmd = 1'b1;
          d.state = TWD_SEQ_IDLE;
        end
      end
    endcase
    d.busy = (d.state != TWD_SEQ_IDLE);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= TWD_SEQ_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign strobes = q.stb;
  assign busy    = q.busy;
  assign overrun = q.overrun;

endmodule

`default_nettype wire

// ===== hdl/twd_reproduce.sv
// Purpose: reproduce-side word deskew for a parallel multitrack digital tape
// Assumes: track pins carry active-high pulses, one per recorded one, asynchronous to clk
// Notes:   each pin passes two flops and a rise detector before any logic reads it

`timescale 1ns/1ps
`default_nettype none

module twd_reproduce
  import twd_pkg::*;
#(
  parameter int unsigned GAP_CYC     = TWD_GAP_CYC,        // strobe spacing in cycles
  parameter int unsigned DLY_MIN_CYC = TWD_DLY_MIN_CYC,    // first delay floor
  parameter int unsigned DLY_MAX_CYC = TWD_DLY_MAX_CYC     // first delay ceiling
)
(
  input  wire logic                     clk,             // system clock
  input  wire logic                     rstn,            // async reset, active low
  input  wire logic [TWD_DATA_BITS-1:0] trackIn,         // data track pulses
  input  wire logic                     frameSyncIn,     // frame-sync track pulse
  input  wire logic                     clockTrackIn,    // clock track pulse
  input  wire twd_cnt_type              firstDelaySel,   // first delay, cycles
  output var  logic                     converterClear,  // first strobe
  output var  logic                     demuxClock,      // second strobe
  output var  logic                     transferCmd,     // third strobe
  output var  logic [TWD_DATA_BITS-1:0] dataPulse,       // released data ones
  output var  logic                     frameSyncOut,    // released frame sync
  output var  logic [TWD_DATA_BITS-1:0] convData,        // converter input register
  output var  logic                     convLoad,        // converter word complete
  output var  logic [TWD_TRACKS-1:0]    storeHeld,       // storage contents
  output var  logic                     seqBusy,         // sequence running
  output var  logic                     seqOverrun,      // clock pulse dropped
  output var  logic                     lateBit          // bit after clear
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (DLY_MIN_CYC < TWD_DLY_LEAD)
  begin : gBadMin
    $error("first delay floor must be at least two cycles");
  end
  if (DLY_MAX_CYC < DLY_MIN_CYC)
  begin : gBadRange
    $error("first delay ceiling below floor");
  end
  if (DLY_MAX_CYC >= (1 << TWD_CNT_W))
  begin : gBadWidth
    $error("first delay ceiling exceeds counter width");
  end
  if (GAP_CYC < 1 || GAP_CYC > (1 << TWD_CNT_W))
  begin : gBadGap
    $error("strobe spacing out of counter range");
  end
  if ((TWD_TRACKS % 2) != 0)
  begin : gBadPairs
    $error("track count must fill whole two-bit units");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  twd_top_reg_type       q;             // registered state
  twd_top_reg_type       d;             // next state
  logic [TWD_PINS-1:0]   pinsIn;        // all raw pins
  logic [TWD_TRACKS-1:0] trackPulse;    // stored-track strobes
  logic                  clkPulse;      // clock-track strobe
  logic [TWD_TRACKS-1:0] relPulse;      // pulses out of storage
  logic [TWD_TRACKS-1:0] heldBits;      // storage contents
  twd_strobe_type        seqStb;        // sequencer strobes
  logic                  busyQ;         // sequencer busy flop
  logic                  overQ;         // sequencer overrun flop

  // ----------------------------------------------------------------
  // pin gathering
  // ----------------------------------------------------------------
  // bit 0 frame sync, data above it, clock track on top
  assign pinsIn = {clockTrackIn, trackIn, frameSyncIn};

  // registered strobes split by role
  assign trackPulse = q.pulse[TWD_TRACKS-1:0];
  assign clkPulse   = q.pulse[TWD_CLKTRK_IDX];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;

    // two-flop synchroniser, first stage feeds only the second
    d.syncA = pinsIn;
    d.syncB = q.syncA;

    // rise detector on settled level, one strobe per pulse
    d.prev  = q.syncB;
    d.pulse = q.syncB & ~q.prev;

    // delayed command lines up with released pulses
    d.cmdDly = seqStb.transferCmd;

    // converter input register: clear first, then load ones
    if (seqStb.converterClear)
    begin
      d.convData = '0;
    end
    else if (q.cmdDly)
    begin
      // all data bits land together in one cycle
      d.convData = q.convData | relPulse[TWD_TRACKS-1:TWD_DATA_LSB];
    end

    // word complete flag rises with the parallel load, two cycles after the command
    d.convLoad = q.cmdDly;

    // track the window between clear and transfer
    if (seqStb.converterClear)
    begin
      d.afterClr = 1'b1;
    end
    else if (seqStb.transferCmd)
    begin
      d.afterClr = 1'b0;
    end

    // bit arriving after clear means the delay is set too short
    d.lateBit = q.afterClr && (|trackPulse);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= TWD_TOP_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // storage: identical two-bit units, one per track pair
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < TWD_PAIRS; gi++)
  begin : gPair
    twd_bit_pair uPair
    (
      .clk      (clk),
      .rstn     (rstn),
      .setPulse (trackPulse[2*gi+1:2*gi]),
      .transfer (seqStb.transferCmd),
      .outPulse (relPulse[2*gi+1:2*gi]),
      .held     (heldBits[2*gi+1:2*gi])
    );
  end

  // ----------------------------------------------------------------
  // delay sequence on the clock track
  // ----------------------------------------------------------------
  twd_strobe_seq
  #(
    .GAP_CYC     (GAP_CYC),
    .DLY_MIN_CYC (DLY_MIN_CYC),
    .DLY_MAX_CYC (DLY_MAX_CYC)
  )
  uSeq
  (
    .clk        (clk),
    .rstn       (rstn),
    .trigger    (clkPulse),
    .firstDelay (firstDelaySel),
    .strobes    (seqStb),
    .busy       (busyQ),
    .overrun    (overQ)
  );

  // ----------------------------------------------------------------
  // outputs, each from a flop here or in a child
  // ----------------------------------------------------------------
  assign converterClear = seqStb.converterClear;
  assign demuxClock     = seqStb.demuxClock;
  assign transferCmd    = seqStb.transferCmd;

  // released pulses: data to converter, sync to demux
  assign dataPulse      = relPulse[TWD_TRACKS-1:TWD_DATA_LSB];
  assign frameSyncOut   = relPulse[TWD_FSYNC_IDX];

  assign convData       = q.convData;
  assign convLoad       = q.convLoad;
  assign storeHeld      = heldBits;
  assign seqBusy        = busyQ;
  assign seqOverrun     = overQ;
  assign lateBit        = q.lateBit;

endmodule

`default_nettype wire

// ===== sim/twd_reproduce_asserts.sv
// Purpose: concurrent checks on the reproduce top ports
// Assumes: strobes and released bits are one-cycle pulses on clk
// Notes:   helper counters measure strobe spacing and first delay
`timescale 1ns/1ps
`default_nettype none
module twd_reproduce_asserts
  import twd_pkg::*;
#(
  parameter int unsigned GAP_CYC     = TWD_GAP_CYC,
  parameter int unsigned DLY_MIN_CYC = TWD_DLY_MIN_CYC,
  parameter int unsigned DLY_MAX_CYC = TWD_DLY_MAX_CYC
)
(
  input wire logic                     clk,
  input wire logic                     rstn,
  input wire logic                     converterClear,
  input wire logic                     demuxClock,
  input wire logic                     transferCmd,
  input wire logic [TWD_DATA_BITS-1:0] dataPulse,
  input wire logic                     frameSyncOut,
  input wire logic [TWD_DATA_BITS-1:0] convData,
  input wire logic                     convLoad,
  input wire logic [TWD_TRACKS-1:0]    storeHeld,
  input wire logic                     seqBusy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [15:0] sinceClr_q;   // cycles since clear strobe
  logic [15:0] sinceBusy_q;  // cycles since busy rose
  logic        busyPrev_q;   // busy one cycle back
  // spacing counters
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sinceClr_q  <= 16'h0000;
      sinceBusy_q <= 16'h0000;
      busyPrev_q  <= 1'b0;
    end
    else
    begin
      sinceClr_q  <= converterClear ? 16'h0001 : sinceClr_q + 16'h0001;
      sinceBusy_q <= (seqBusy && !busyPrev_q) ? 16'h0001 : sinceBusy_q + 16'h0001;
      busyPrev_q  <= seqBusy;
    end
  end
  // clear then empty converter register
  sequence sClearDone;
    converterClear ##1 (convData == '0);
  endsequence
  // release then load of the converter
  sequence sLoadWord;
    transferCmd ##2 (convLoad && convData == $past(storeHeld[TWD_TRACKS-1:1], 2));
  endsequence
  a_clear_zeroes: assert property (converterClear |-> sClearDone)
    else $error("converter register not zero after clear");
  a_demux_gap: assert property (demuxClock |-> sinceClr_q == 16'(GAP_CYC))
    else $error("demux clock spacing wrong");
  a_cmd_gap: assert property (transferCmd |-> sinceClr_q == 16'(2*GAP_CYC))
    else $error("transfer command spacing wrong");
  a_first_delay: assert property (converterClear |-> sinceBusy_q >= 16'(DLY_MIN_CYC-1)
    && sinceBusy_q <= 16'(DLY_MAX_CYC-1)) else $error("first delay out of range");
  a_release_bits: assert property (transferCmd |=> dataPulse == $past(storeHeld[TWD_TRACKS-1:1])
    && frameSyncOut == $past(storeHeld[0])) else $error("released bits differ from store");
  a_load_word: assert property (transferCmd |-> sLoadWord)
    else $error("converter word not loaded");
  a_no_stray: assert property ((|dataPulse || frameSyncOut) |-> $past(transferCmd))
    else $error("pulse without transfer");
  a_store_holds: assert property (|($past(storeHeld) & ~storeHeld) |-> $past(transferCmd))
    else $error("stored bit lost before transfer");
  a_one_strobe: assert property ($onehot0({converterClear, demuxClock, transferCmd}))
    else $error("strobes overlap");
  a_busy_end: assert property (transferCmd |-> !seqBusy && $past(seqBusy))
    else $error("sequence busy wrong at transfer");
endmodule
bind twd_reproduce twd_reproduce_asserts #(.GAP_CYC(GAP_CYC), .DLY_MIN_CYC(DLY_MIN_CYC),
  .DLY_MAX_CYC(DLY_MAX_CYC)) chk (.clk(clk), .rstn(rstn), .converterClear(converterClear),
  .demuxClock(demuxClock), .transferCmd(transferCmd), .dataPulse(dataPulse),
  .frameSyncOut(frameSyncOut), .convData(convData), .convLoad(convLoad),
  .storeHeld(storeHeld), .seqBusy(seqBusy));
`default_nettype wire

// ===== sim/twd_tape_model.sv
// Purpose: tape read side, one word of skewed track pulses then a clock pulse
// Assumes: go is a one-cycle request; word holds steady during the word
// Notes:   pins idle low between words, as the read amplifiers rest
`timescale 1ns/1ps
`default_nettype none
module twd_tape_model
  import twd_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     go,
  input  wire logic [TWD_TRACKS-1:0]    word,
  output var  logic [TWD_DATA_BITS-1:0] trackIn,
  output var  logic                     frameSyncIn,
  output var  logic                     clockTrackIn
);
  logic [3:0]            cnt_q = 4'h0;  // position within the word
  logic [TWD_TRACKS-1:0] lvl;           // track levels, store order
  // word timer, pins move on the falling edge
  always @(negedge clk)
  begin
    if (go)
      cnt_q <= 4'h1;
    else
      cnt_q <= (cnt_q == 4'h0 || cnt_q == 4'hf) ? 4'h0 : cnt_q + 4'h1;
  end
  // ones only give pulses, each track skewed by up to two cycles
  always_comb
  begin
    for (int j = 0; j < TWD_TRACKS; j++)
      lvl[j] = word[j] && cnt_q > 4'(j % 3) && cnt_q <= 4'(j % 3 + 3);
    trackIn      = lvl[TWD_TRACKS-1:1];
    frameSyncIn  = lvl[0];
    clockTrackIn = cnt_q >= 4'h6 && cnt_q <= 4'h9;
  end
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Purpose: self-checking bench for the word deskew reproduce top
// Assumes: short strobe counts set by parameters for a quick run
// Notes:   all pins driven on the falling edge, outputs read there too
`timescale 1ns/1ps
`default_nettype none
module tb;
  import twd_pkg::*;
  localparam int GAP = 4;             // strobe spacing
  localparam int DMIN = 4;            // first delay floor
  localparam int DMAX = 10;           // first delay ceiling
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic go = 1'b0;
  logic [TWD_TRACKS-1:0] word = '0;
  twd_cnt_type firstDelaySel = 8'h06;
  logic [TWD_DATA_BITS-1:0] trackIn, dataPulse, convData;
  logic frameSyncIn, clockTrackIn, converterClear, demuxClock, transferCmd;
  logic frameSyncOut, convLoad, seqBusy, seqOverrun, lateBit;
  logic [TWD_TRACKS-1:0] storeHeld;
  int mismatches = 0;
  int checks_done = 0;
  always #50 clk = ~clk;
  twd_tape_model tape (.clk(clk), .go(go), .word(word), .trackIn(trackIn),
    .frameSyncIn(frameSyncIn), .clockTrackIn(clockTrackIn));
  twd_reproduce #(.GAP_CYC(GAP), .DLY_MIN_CYC(DMIN), .DLY_MAX_CYC(DMAX)) dut (
    .clk(clk), .rstn(rstn), .trackIn(trackIn), .frameSyncIn(frameSyncIn),
    .clockTrackIn(clockTrackIn), .firstDelaySel(firstDelaySel),
    .converterClear(converterClear), .demuxClock(demuxClock), .transferCmd(transferCmd),
    .dataPulse(dataPulse), .frameSyncOut(frameSyncOut), .convData(convData),
    .convLoad(convLoad), .storeHeld(storeHeld), .seqBusy(seqBusy),
    .seqOverrun(seqOverrun), .lateBit(lateBit));
  // compare and count
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic close_out;
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one word through the tape and the strobe sequence
  task automatic run_word(input logic [TWD_TRACKS-1:0] w, input logic [7:0] sel, input int d);
    int t0, tc, td, tx, tl;
    t0 = -999; tc = -999; td = -999; tx = -999; tl = -999;
    @(negedge clk);
    word <= w;
    firstDelaySel <= sel;
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    for (int n = 0; n < 120 && tl < 0; n++)
    begin
      @(negedge clk);
      if (clockTrackIn && t0 < 0)
        t0 = n;
      if (converterClear)
      begin
        tc = n;
        chk("stored word", 16'(storeHeld), 16'(w));
      end
      if (n == tc + 1)
        chk("cleared converter", 16'(convData), 16'h0000);
      if (demuxClock)
        td = n;
      if (transferCmd)
        tx = n;
      if (n == tx + 1)
      begin
        chk("data pulses", 16'(dataPulse), 16'(w[TWD_TRACKS-1:1]));
        chk("sync pulse", 16'(frameSyncOut), 16'(w[0]));
        chk("store emptied", 16'(storeHeld), 16'h0000);
      end
      if (convLoad)
      begin
        tl = n;
        chk("converter word", 16'(convData), 16'(w[TWD_TRACKS-1:1]));
      end
    end
    if (tl < 0)
    begin
      mismatches++;
      close_out();
    end
    else
    begin
      chk("first delay", 16'(tc - t0), 16'(d + 2));
      chk("demux gap", 16'(td - tc), 16'(GAP));
      chk("command gap", 16'(tx - td), 16'(GAP));
      chk("load lag", 16'(tl - tx), 16'h0002);
    end
  endtask
  // reset in the middle of a sequence empties store and sequencer
  task automatic sc_mid_reset;
    @(negedge clk);
    word <= 10'h3ff;
    firstDelaySel <= 8'hc8;
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    repeat (11) @(negedge clk);
    rstn <= 1'b0;
    @(negedge clk);
    chk("reset store", 16'(storeHeld), 16'h0000);
    chk("reset busy", 16'(seqBusy), 16'h0000);
    repeat (8) @(negedge clk);
    rstn <= 1'b1;
  endtask
  // bits arriving after the clear, clock pulse while the run is busy
  task automatic sc_late_overrun;
    int late, over;
    late = 0;
    over = 0;
    @(negedge clk);
    word <= 10'h000;
    firstDelaySel <= 8'hc8;
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    for (int n = 2; n < 60; n++)
    begin
      @(negedge clk);
      if (n == DMAX + 6)
      begin
        word <= 10'h3ff;
        go <= 1'b1;
      end
      if (n == DMAX + 7)
        go <= 1'b0;
      if (n == DMAX + 2*GAP + 10)
        chk("late word out", 16'(dataPulse), 16'h01ff);
      late += int'(lateBit === 1'b1);
      over += int'(seqOverrun === 1'b1);
    end
    chk("late bits", 16'(late), 16'h0003);
    chk("dropped clock", 16'(over), 16'h0001);
  endtask
  // every track a one, mid-range delay
  task automatic sc_all_ones;
    run_word(10'h3ff, 8'h06, 6);
  endtask
  // an all-zero word stays silent
  task automatic sc_zero_word;
    run_word(10'h000, 8'h06, 6);
  endtask
  // request below the floor is clamped up
  task automatic sc_clamp_low;
    run_word(10'h155, 8'h02, DMIN);
  endtask
  // request above the ceiling is clamped down
  task automatic sc_clamp_high;
    run_word(10'h2aa, 8'hc8, DMAX);
  endtask
  // main sequence
  initial
  begin
    repeat (4) @(negedge clk);
    rstn <= 1'b1;
    sc_all_ones();
    sc_zero_word();
    sc_mid_reset();
    sc_late_overrun();
    sc_clamp_low();
    sc_clamp_high();
    repeat (5) @(negedge clk);
    close_out();
  end
endmodule
`default_nettype wire
